/* dmab_top.sv */
// Two-slice multiply-accumulate block with APB configuration registers.
//
// Contract
// - Block holds two identical chainable slices.
// - Products: 36x36, two 18x36, four 18x18, eight 9x9.
// - Accumulate 18x36, two 18x18 or four 9x9.
// - Two 18x18 products feed one 54-bit accumulator.
// - Multiply, accumulate, add/sub, add/sub-sum elements.
// - Element counts per width as tabulated.
// - Operand register loads parallel or from chain.
// - Dynamic add/subtract of accumulator every cycle.
// - Dynamic choice of parallel or shift loading.
// - Synchronous reset, optional asynchronous reset.
// - Dynamic function select each clock cycle.
// - Symmetric pre-adder with odd and even modes.
// - 2D symmetric filters via slices and cascade.
// - Registered cascade paths continue across rows.
// - Selectable saturation and rounding on accumulate, add/sub and sum results.
`timescale 1ns/1ps
`default_nettype none
`include "dmab_cfg.svh"
module dmab_top #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dsp_rst,
  input wire logic [1:0][35:0] a_in,
  input wire logic [1:0][35:0] b_in,
  input wire logic [1:0][35:0] c_in,
  input wire logic [35:0] a_chain_in,
  input wire logic [1:0] ld_shift,
  input wire logic [1:0] sub,
  input wire logic [1:0][3:0] op_sel,
  input wire logic [53:0] cas_in,
  output logic [35:0] a_chain_out,
  output logic [53:0] cas_out,
  output logic [1:0][71:0] res
);
  typedef struct packed {
    logic [`DMAB_CTRL_W-1:0] ctrl;
    logic [`DMAB_MODE_W-1:0] mode;
    logic [`DMAB_RND_W-1:0] rpos;
    logic [1:0] ovf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dmab_bus_type;
  typedef struct packed {
    logic [1:0][35:0] a;
    logic [1:0][35:0] b;
    logic [1:0][35:0] c;
    logic [1:0][35:0] cd;
    dmab_pkg::dmab_op_type [1:0] op1;
    logic [1:0] sub1;
    dmab_pkg::dmab_op_type [1:0] op2;
    logic [1:0] sub2;
    logic [53:0] casr;
    logic [1:0][53:0] acc;
    logic [1:0][71:0] res;
    logic [1:0] ovf;
  } dmab_dp_type;
  dmab_bus_type bs_r;
  dmab_bus_type bs_nxt;
  dmab_dp_type dp_r;
  dmab_dp_type dp_nxt;
  logic dyn;
  logic async_en;
  logic sgn_a;
  logic sgn_b;
  logic sat_en;
  logic rnd_en;
  logic odd;
  logic shld;
  logic cmb;
  dmab_pkg::dmab_sym_type sym;
  dmab_pkg::dmab_wid_type wid;
  logic arst_n;
  logic [1:0][3:0][36:0] ax;
  logic [1:0][3:0][36:0] bx;
  logic [1:0][3:0][55:0] mp;
  assign dyn = bs_r.ctrl[`DMAB_CTRL_DYN];
  assign async_en = bs_r.ctrl[`DMAB_CTRL_ASYNC];
  assign sgn_a = bs_r.ctrl[`DMAB_CTRL_SGNA];
  assign sgn_b = bs_r.ctrl[`DMAB_CTRL_SGNB];
  assign sat_en = bs_r.ctrl[`DMAB_CTRL_SAT];
  assign rnd_en = bs_r.ctrl[`DMAB_CTRL_RND];
  assign odd = bs_r.ctrl[`DMAB_CTRL_ODD];
  assign shld = bs_r.ctrl[`DMAB_CTRL_SHLD];
  assign sym = dmab_pkg::dmab_sym_type'(bs_r.ctrl[`DMAB_CTRL_SYM +: 2]);
  assign wid = dmab_pkg::dmab_wid_type'(bs_r.mode[`DMAB_MODE_WID +: 3]);
  assign cmb = bs_r.mode[`DMAB_MODE_CMB];
  // With the asynchronous option set, the datapath reset also clears without a clock edge.
  assign arst_n = presetn & ~(async_en & dsp_rst);
  // Picks lane i of width n, zero beyond the lane count, sign-extended to 37 bits when sg is set, else zero-extended.
  function automatic logic [36:0] lane(input logic [35:0] x, input int n, input int cnt, input int i,
                                       input logic sg);
    logic [35:0] m;
    logic [35:0] v;
    logic s;
    m = 36'hF_FFFF_FFFF >> (36 - n);
    v = (x >> (n * i)) & m;
    s = sg & v[n-1];
    if (i >= cnt) begin
      return 37'h0_0000_0000;
    end
    return {s, s ? (v | ~m) : v};
  endfunction : lane
  function automatic logic [53:0] sat(input logic [55:0] x, input logic en);
    if (x[55:53] == 3'h0 || x[55:53] == 3'h7 || !en) begin
      return x[53:0];
    end
    return x[55] ? 54'h20_0000_0000_0000 : 54'h1F_FFFF_FFFF_FFFF;
  endfunction : sat
  // Round half up at bit position pos and clear the bits below it.
  function automatic logic [55:0] rnd(input logic [55:0] x, input logic en, input logic [5:0] pos);
    logic [55:0] h;
    h = 56'h1 << pos;
    if (!en || pos == 6'h00) begin
      return x;
    end
    return (x + (h >> 1)) & ~(h - 56'h1);
  endfunction : rnd
  always_comb begin
    bs_nxt = bs_r;
    bs_nxt.pready = psel & penable & ~bs_r.pready;
    bs_nxt.pslverr = 1'b0;
    bs_nxt.ovf = bs_r.ovf | dp_r.ovf;
    if (psel & penable & ~bs_r.pready) begin
      bs_nxt.prdata = 32'h0000_0000;
      case (paddr)
        `DMAB_CTRL_OFS: begin
          bs_nxt.prdata = {22'h00_0000, bs_r.ctrl};
        end
        `DMAB_MODE_OFS: begin
          bs_nxt.prdata = {20'h0_0000, bs_r.mode};
        end
        `DMAB_RND_OFS: begin
          bs_nxt.prdata = {26'h000_0000, bs_r.rpos};
        end
        `DMAB_STAT_OFS: begin
          bs_nxt.prdata = {30'h0000_0000, bs_r.ovf};
        end
        default: begin
          bs_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (psel & penable & bs_r.pready & pwrite) begin
      case (paddr)
        `DMAB_CTRL_OFS: begin
          bs_nxt.ctrl = pwdata[`DMAB_CTRL_W-1:0];
        end
        `DMAB_MODE_OFS: begin
          bs_nxt.mode = pwdata[`DMAB_MODE_W-1:0];
        end
        `DMAB_RND_OFS: begin
          bs_nxt.rpos = pwdata[`DMAB_RND_W-1:0];
        end
        `DMAB_STAT_OFS: begin
          // Write one to clear; a new overflow in the same cycle keeps the bit set.
          bs_nxt.ovf = (bs_r.ovf & ~pwdata[1:0]) | dp_r.ovf;
        end
        default: begin
          bs_nxt.ctrl = bs_r.ctrl;
        end
      endcase
    end
    if (!ce) begin
      bs_nxt = bs_r;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bs_r <= '{ctrl: `DMAB_CTRL_RST, mode: `DMAB_MODE_RST, rpos: `DMAB_RND_RST, default: '0};
    end else begin
      bs_r <= bs_nxt;
    end
  end

  // Operand lanes for both slices, with the symmetric pre-adder in front of B.
  always_comb begin
    int na;
    int nb;
    int cnt;
    logic sa;
    logic [36:0] bl;
    logic [36:0] cl;
    logic [35:0] cc;
    na = 18;
    nb = 36;
    cnt = 1;
    sa = 1'b0;
    bl = 37'h0_0000_0000;
    cl = 37'h0_0000_0000;
    cc = 36'h0_0000_0000;
    ax = '0;
    bx = '0;
    for (int s = 0; s < 2; s++) begin
      na = (wid == dmab_pkg::wid_9) ? 9 : 18;
      nb = (wid == dmab_pkg::wid_9) ? 9 : (wid == dmab_pkg::wid_18) ? 18 : 36;
      cnt = (wid == dmab_pkg::wid_9) ? 4 : (wid == dmab_pkg::wid_18) ? 2 : 1;
      // The low half of a 36x36 product is unsigned whatever the A setting.
      sa = sgn_a & ~(cmb & (s == 0));
      cc = odd ? dp_r.cd[s] : dp_r.c[s];
      for (int i = 0; i < 4; i++) begin
        ax[s][i] = lane(dp_r.a[s], na, cnt, i, sa);
        bl = lane(dp_r.b[s], nb, cnt, i, sgn_b);
        cl = lane(cc, nb, cnt, i, sgn_b);
        case (sym)
          dmab_pkg::sym_pos: begin
            bx[s][i] = bl + cl;
          end
          dmab_pkg::sym_neg: begin
            bx[s][i] = bl - cl;
          end
          default: begin
            bx[s][i] = bl;
          end
        endcase
      end
    end
  end

  for (genvar s = 0; s < 2; s++) begin : g_slice
    dmab_mulstage #(
      .LANES(4),
      .OW(37),
      .PW(`DMAB_PW)
    ) u_mul (
      .pclk(pclk),
      .ce(ce),
      .arst_n(arst_n),
      .srst(dsp_rst),
      .a_x(ax[s]),
      .b_x(bx[s]),
      .p(mp[s])
    );
  end

  always_comb begin
    logic [55:0] sp;
    logic [55:0] lo;
    logic [55:0] hi;
    logic [55:0] adsv;
    logic [55:0] casv;
    logic [55:0] accx;
    logic [55:0] wide;
    logic [71:0] pk;
    dmab_pkg::dmab_op_type op;
    sp = 56'h0;
    lo = 56'h0;
    hi = 56'h0;
    adsv = 56'h0;
    casv = 56'h0;
    accx = 56'h0;
    wide = 56'h0;
    pk = 72'h0;
    op = dmab_pkg::op_mul;
    dp_nxt = dp_r;
    for (int s = 0; s < 2; s++) begin
      // Stage one: operand and control registers.
      if (dyn ? ld_shift[s] : shld) begin
        dp_nxt.a[s] = (s == 0) ? a_chain_in : dp_r.a[0];
      end else begin
        dp_nxt.a[s] = a_in[s];
      end
      dp_nxt.b[s] = b_in[s];
      dp_nxt.c[s] = c_in[s];
      dp_nxt.cd[s] = dp_r.c[s];
      if (dyn) begin
        dp_nxt.op1[s] = dmab_pkg::dmab_op_type'(op_sel[s]);
        dp_nxt.sub1[s] = sub[s];
      end else begin
        dp_nxt.op1[s] = dmab_pkg::dmab_op_type'(bs_r.mode[4*s +: 4]);
        dp_nxt.sub1[s] = 1'b0;
      end
      // Stage two: controls travel with the products.
      dp_nxt.op2[s] = dp_r.op1[s];
      dp_nxt.sub2[s] = dp_r.sub1[s];
      // Stage three: summation, accumulation, cascade and output shaping.
      sp = mp[s][0] + mp[s][1] + mp[s][2] + mp[s][3];
      lo = (wid == dmab_pkg::wid_9) ? mp[s][0] + mp[s][1] : mp[s][0];
      hi = (wid == dmab_pkg::wid_9) ? mp[s][2] + mp[s][3] : mp[s][1];
      adsv = dp_r.sub2[s] ? lo - hi : lo + hi;
      casv = (s == 0) ? {{2{dp_r.casr[53]}}, dp_r.casr} : {{2{dp_r.acc[0][53]}}, dp_r.acc[0]};
      accx = {{2{dp_r.acc[s][53]}}, dp_r.acc[s]};
      op = dp_r.op2[s];
      // At full width only multiply and accumulate of 18x36 exist.
      if (wid == dmab_pkg::wid_36 && op != dmab_pkg::op_acc) begin
        op = dmab_pkg::op_mul;
      end
      case (op)
        dmab_pkg::op_acc: begin
          wide = dp_r.sub2[s] ? accx - sp : accx + sp;
        end
        dmab_pkg::op_ads: begin
          wide = adsv;
        end
        dmab_pkg::op_sum: begin
          wide = adsv + casv;
        end
        default: begin
          wide = sp;
        end
      endcase
      case (wid)
        dmab_pkg::wid_9: begin
          pk = {mp[s][3][17:0], mp[s][2][17:0], mp[s][1][17:0], mp[s][0][17:0]};
        end
        dmab_pkg::wid_18: begin
          pk = {mp[s][1][35:0], mp[s][0][35:0]};
        end
        default: begin
          pk = {{16{mp[s][0][55]}}, mp[s][0]};
          if (cmb && s == 1) begin
            pk = {{16{mp[0][0][55]}}, mp[0][0]} + ({{16{mp[1][0][55]}}, mp[1][0]} << 18);
          end
        end
      endcase
      dp_nxt.ovf[s] = (wide[55:53] != 3'h0) && (wide[55:53] != 3'h7);
      dp_nxt.acc[s] = sat(wide, sat_en);
      if (op == dmab_pkg::op_mul) begin
        dp_nxt.res[s] = pk;
      end else begin
        pk = {{16{1'b0}}, rnd(wide, rnd_en, bs_r.rpos)};
        pk = {18'h0_0000, sat(pk[55:0], sat_en)};
        dp_nxt.res[s] = {{18{pk[53]}}, pk[53:0]};
      end
    end
    dp_nxt.casr = cas_in;
    if (dsp_rst) begin
      dp_nxt = '0;
    end else if (!ce) begin
      dp_nxt = dp_r;
    end
  end

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      dp_r <= '0;
    end else begin
      dp_r <= dp_nxt;
    end
  end

  assign prdata = bs_r.prdata;
  assign pready = bs_r.pready;
  assign pslverr = bs_r.pslverr;
  assign a_chain_out = dp_r.a[1];
  assign cas_out = dp_r.acc[1];
  assign res = dp_r.res;
endmodule : dmab_top
`default_nettype wire

/* dmab_cfg.svh */
// Offsets, field positions, reset values and widths of the multiply-accumulate block.
`ifndef DMAB_CFG_SVH
`define DMAB_CFG_SVH
`define DMAB_ACC_W 54
`define DMAB_PW 56
`define DMAB_CTRL_OFS 12'h000
`define DMAB_MODE_OFS 12'h004
`define DMAB_RND_OFS 12'h008
`define DMAB_STAT_OFS 12'h00C
`define DMAB_CTRL_DYN 0
`define DMAB_CTRL_ASYNC 1
`define DMAB_CTRL_SGNA 2
`define DMAB_CTRL_SGNB 3
`define DMAB_CTRL_SAT 4
`define DMAB_CTRL_RND 5
`define DMAB_CTRL_SYM 6
`define DMAB_CTRL_ODD 8
`define DMAB_CTRL_SHLD 9
`define DMAB_CTRL_W 10
`define DMAB_MODE_OP0 0
`define DMAB_MODE_OP1 4
`define DMAB_MODE_WID 8
`define DMAB_MODE_CMB 11
`define DMAB_MODE_W 12
`define DMAB_RND_W 6
`define DMAB_CTRL_RST 10'h00C
`define DMAB_MODE_RST 12'h211
`define DMAB_RND_RST 6'h00
`endif

/* dmab_pkg.sv */
// Types shared by the multiply-accumulate block.
package dmab_pkg;
  typedef enum logic [3:0] {
    op_mul = 4'h1,
    op_acc = 4'h2,
    op_ads = 4'h4,
    op_sum = 4'h8
  } dmab_op_type;
  typedef enum logic [2:0] {
    wid_9 = 3'h1,
    wid_18 = 3'h2,
    wid_36 = 3'h4
  } dmab_wid_type;
  typedef enum logic [1:0] {
    sym_off = 2'h0,
    sym_pos = 2'h1,
    sym_neg = 2'h2
  } dmab_sym_type;
endpackage : dmab_pkg

/* dmab_mulstage.sv */
// Registered lane multiplier array of one arithmetic slice.
`timescale 1ns/1ps
`default_nettype none
module dmab_mulstage #(
  parameter int LANES = 4,
  parameter int OW = 37,
  parameter int PW = 56
) (
  input wire logic pclk,
  input wire logic ce,
  input wire logic arst_n,
  input wire logic srst,
  input wire logic [LANES-1:0][OW-1:0] a_x,
  input wire logic [LANES-1:0][OW-1:0] b_x,
  output logic [LANES-1:0][PW-1:0] p
);
  typedef struct packed {
    logic [LANES-1:0][PW-1:0] p;
  } dmab_ms_type;

  dmab_ms_type st_r;
  dmab_ms_type st_nxt;
  logic [LANES-1:0][PW-1:0] prod_w;

  function automatic logic [PW-1:0] prod(input logic [OW-1:0] a, input logic [OW-1:0] b);
    logic signed [2*OW-1:0] m;
    m = $signed(a) * $signed(b);
    return m[PW-1:0];
  endfunction : prod

  // Each lane multiplies two sign- or zero-extended operands; the extension carries the signedness.
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign prod_w[i] = prod(a_x[i], b_x[i]);
  end

  always_comb begin
    st_nxt = st_r;
    if (srst) begin
      st_nxt = '0;
    end else if (ce) begin
      st_nxt.p = prod_w;
    end
  end

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign p = st_r.p;
endmodule : dmab_mulstage
`default_nettype wire

/* dmab_props.sv */
// Port-level checks of the multiply-accumulate block.
`timescale 1ns/1ps
`default_nettype none
module dmab_props #(
  parameter int AW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dsp_rst,
  input wire logic [35:0] a_chain_out,
  input wire logic [53:0] cas_out,
  input wire logic [1:0][71:0] res
);
  logic mapped;
  assign mapped = (paddr[AW-1:4] == '0) && (paddr[1:0] == 2'h0);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_answer: assert property (psel && penable && !pready && ce |=> pready)
    else $error("pready not after one wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_xfer: assert property (pready |-> psel && penable && $past(psel))
    else $error("pready outside a transfer");
  chk_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  chk_err_rdata: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_reset_clear: assert property ($rose(presetn) |-> res == '0 && cas_out == 54'h0 && !pready)
    else $error("outputs not cleared by reset");
  chk_dsp_clear: assert property (dsp_rst |=> res == '0 && cas_out == 54'h0 && a_chain_out == 36'h0)
    else $error("datapath reset did not clear");
  chk_ce_freeze: assert property (!ce && !dsp_rst |=> $stable(res) && $stable(a_chain_out) && $stable(pready))
    else $error("registers moved while disabled");
endmodule : dmab_props
`default_nettype wire

/* dmab_nbr.sv */
// Neighbouring slice model feeding the chain and cascade inputs.
`timescale 1ns/1ps
`default_nettype none
module dmab_nbr (
  input wire logic pclk,
  input wire logic ld,
  input wire logic [53:0] val,
  output logic [35:0] a_chain_in,
  output logic [53:0] cas_in
);
  logic [53:0] val_r = 54'h0;
  // An idle neighbour shows a changing pattern, never a held stale value.
  always @(posedge pclk) begin
    val_r <= ld ? val : ~val_r;
  end
  assign a_chain_in = val_r[35:0];
  assign cas_in = val_r;
endmodule : dmab_nbr
`default_nettype wire

/* dsp_plain_multiply_element_accum_block_bench.sv */
// Self-checking bench of the multiply-accumulate block.
`timescale 1ns/1ps
`default_nettype none
module dsp_plain_multiply_element_accum_block_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic dsp_rst = 1'b0;
  logic [1:0][35:0] a_in = '0;
  logic [1:0][35:0] b_in = '0;
  logic [1:0][35:0] c_in = '0;
  logic [1:0] ld_shift = 2'h0;
  logic [1:0] sub = 2'h0;
  logic [1:0][3:0] op_sel = 8'h11;
  logic ld = 1'b0;
  logic [53:0] val = 54'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  logic [35:0] a_chain_in, a_chain_out;
  logic [53:0] cas_in, cas_out;
  logic [1:0][71:0] res;
  int bad_count = 0;
  int total_checks = 0;
  always #10 pclk = ~pclk;
  dmab_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dsp_rst(dsp_rst),
    .a_in(a_in), .b_in(b_in), .c_in(c_in), .a_chain_in(a_chain_in), .ld_shift(ld_shift), .sub(sub),
    .op_sel(op_sel), .cas_in(cas_in), .a_chain_out(a_chain_out), .cas_out(cas_out), .res(res));
  dmab_nbr nbr_u (.pclk(pclk), .ld(ld), .val(val), .a_chain_in(a_chain_in), .cas_in(cas_in));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      bad_count++;
      finish_test();
    end
  endtask : apb
  task automatic t_regs();
    logic [31:0] tab [4];
    tab = '{32'h00C, 32'h211, 32'h000, 32'h000};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk("reset value", {40'h0, tab[i]}, {40'h0, rd});
    end
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 72'h1_0000_0000, {39'h0, er, rd});
    $display("test regs done");
  endtask : t_regs
  task automatic t_mul();
    @(posedge pclk);
    a_in[0] <= {18'h3FFFE, 18'h00003};
    b_in[0] <= {18'h00007, 18'h00005};
    cyc(4);
    chk("mul x18", {36'hFFFFFFFF2, 36'h00000000F}, res[0]);
    apb(1'b1, 12'h004, 32'h111);
    @(posedge pclk);
    a_in[0] <= {9'h1FF, 9'h002, 9'h003, 9'h004};
    b_in[0] <= {9'h005, 9'h006, 9'h007, 9'h008};
    cyc(4);
    chk("mul x9", {18'h3FFFB, 18'h0000C, 18'h00015, 18'h00020}, res[0]);
    apb(1'b1, 12'h004, 32'h411);
    @(posedge pclk);
    a_in[0] <= 36'h000000003;
    b_in[0] <= 36'hFFFFFFFFF;
    cyc(4);
    chk("mul x36", 72'hFF_FFFF_FFFF_FFFF_FFFD, res[0]);
    apb(1'b1, 12'h004, 32'h211);
    $display("test mul done");
  endtask : t_mul
  task automatic t_acc();
    apb(1'b1, 12'h000, 32'h00D);
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl", 72'h00D, {40'h0, rd});
    @(posedge pclk);
    dsp_rst <= 1'b1;
    @(posedge pclk);
    dsp_rst <= 1'b0;
    a_in[0] <= {18'h00001, 18'h00002};
    b_in[0] <= {18'h00003, 18'h00004};
    op_sel[0] <= 4'h2;
    @(posedge pclk);
    a_in[0] <= {18'h00001, 18'h00005};
    sub[0] <= 1'b1;
    @(posedge pclk);
    op_sel[0] <= 4'h1;
    sub[0] <= 1'b0;
    cyc(1);
    chk("acc add", 72'h0B, {18'h0, res[0][53:0]});
    cyc(1);
    chk("acc sub", 72'h3FFFFFFFFFFFF4, {18'h0, res[0][53:0]});
    cyc(1);
    chk("op switch", {36'h3, 36'h14}, res[0]);
    $display("test acc done");
  endtask : t_acc
  task automatic t_shift();
    @(posedge pclk);
    ld <= 1'b1;
    val <= 54'h0ABCD12345;
    ld_shift <= 2'h3;
    cyc(5);
    chk("shift load", 72'hABCD12345, {36'h0, a_chain_out});
    @(posedge pclk);
    ld_shift <= 2'h0;
    a_in[1] <= 36'h123456789;
    cyc(4);
    chk("parallel load", 72'h123456789, {36'h0, a_chain_out});
    apb(1'b1, 12'h000, 32'h20C);
    cyc(4);
    chk("static shift", 72'hABCD12345, {36'h0, a_chain_out});
    @(posedge pclk);
    ce <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    ce <= 1'b1;
    dsp_rst <= 1'b1;
    @(posedge pclk);
    dsp_rst <= 1'b0;
    ld <= 1'b0;
    cyc(0);
    chk("datapath clear", 72'h0, res[1]);
    $display("test shift done");
  endtask : t_shift
  task automatic t_filt();
    apb(1'b1, 12'h000, 32'h04C);
    @(posedge pclk);
    a_in[0] <= {18'h00002, 18'h00003};
    b_in[0] <= {18'h00004, 18'h00005};
    c_in[0] <= {18'h00001, 18'h00001};
    cyc(4);
    chk("pre-add", {36'hA, 36'h12}, res[0]);
    apb(1'b1, 12'h000, 32'h00C);
    apb(1'b1, 12'h004, 32'h288);
    @(posedge pclk);
    a_in[1] <= 36'h000040001;
    b_in[1] <= 36'h000040001;
    ld <= 1'b1;
    val <= 54'h100;
    cyc(6);
    chk("sum cascade", 72'h117, res[0]);
    chk("row cascade", 72'h119, {18'h0, cas_out});
    apb(1'b1, 12'h000, 32'h01C);
    @(posedge pclk);
    val <= 54'h1F_FFFF_FFFF_FFFF;
    cyc(6);
    chk("saturate", 72'h1F_FFFF_FFFF_FFFF, res[0]);
    apb(1'b0, 12'h00C, 32'h0);
    chk("overflow flag", 72'h3, {40'h0, rd});
    @(posedge pclk);
    val <= 54'h100;
    cyc(6);
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b0, 12'h00C, 32'h0);
    chk("overflow clear", 72'h0, {40'h0, rd});
    apb(1'b1, 12'h008, 32'h4);
    apb(1'b1, 12'h000, 32'h02C);
    cyc(3);
    chk("round", 72'h110, res[0]);
    chk("cascade unrounded", 72'h119, {18'h0, cas_out});
    apb(1'b1, 12'h004, 32'hC11);
    @(posedge pclk);
    a_in[0] <= 36'h3;
    a_in[1] <= 36'h1;
    b_in[0] <= 36'h5;
    b_in[1] <= 36'h5;
    cyc(4);
    chk("mul 36x36", 72'h14000F, res[1]);
    $display("test filt done");
  endtask : t_filt
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_mul();
    t_acc();
    t_shift();
    t_filt();
    finish_test();
  end
endmodule : dsp_plain_multiply_element_accum_block_bench
bind dmab_top dmab_props #(.AW(AW)) props_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dsp_rst(dsp_rst), .a_chain_out(a_chain_out), .cas_out(cas_out), .res(res));
`default_nettype wire
